// >>> common/sicond_pkg.sv
// Package of constants and types for the supply input conditioning block
package sicond_pkg;
   // Clock and timing
   localparam int CLK_HZ          = 50_000_000;
   localparam int FILT_MAX_US     = 100;
   localparam int FILT_MAX_CYC    = (FILT_MAX_US * (CLK_HZ / 1_000_000));
   localparam int TMR_W           = 13;
   localparam int RR_FULL_MS      = 20;
   localparam int RR_FULL_CYC     = RR_FULL_MS * (CLK_HZ / 1000);
   // Channel counts
   localparam int N_SFD           = 10;
   localparam int N_DED           = 5;
   localparam int N_AUX           = 5;
   localparam int N_ADC           = 13;
   localparam int ADC_W           = 12;
   localparam int AVG_CNT         = 16;
   localparam int AVG_SH          = 4;
   localparam int ACC_W           = ADC_W + AVG_SH;
   localparam logic [ADC_W-1:0] ADC_FULL = 12'hfff;
   // Per-channel conversion time in cycles; temperature channels dominate
   localparam int VOLT_CONV_CYC   = 10_000;
   localparam int TEMP_CONV_CYC   = 300_000;
   localparam int FIRST_TEMP_CH   = 10;
   // Register map (word index = offset / 4)
   localparam int ADDR_W          = 8;
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_AUXMODE  = 8'h04;
   localparam logic [7:0] A_CHSEL    = 8'h08;
   localparam logic [7:0] A_LIMDIR   = 8'h0c;
   localparam logic [7:0] A_STATUS   = 8'h10;
   localparam logic [7:0] A_WARN     = 8'h14;
   localparam logic [7:0] A_FILT0    = 8'h20;
   localparam logic [7:0] A_PW0      = 8'h48;
   localparam logic [7:0] A_LIM0     = 8'h60;
   localparam logic [7:0] A_RES0     = 8'ha0;
   // Field positions
   localparam int CTRL_RUN        = 0;
   localparam int CTRL_AVG        = 1;
   localparam int AUX_EDGE_LSB    = 8;
   // Reset values
   localparam logic [12:0] CHSEL_RST = 13'h1fff;
   typedef enum logic [2:0] {
      SIC_IDLE = 3'b001,
      SIC_CONV = 3'b010,
      SIC_DONE = 3'b100
   } sic_rr_t;
endpackage

// >>> rtl/sicond_core.sv
// Supply input glitch filters, aux dual inputs and ADC round-robin scheduler
// How it works
// - Pulses shorter than timeout never reach output
// - Longer pulses pass, delayed by timeout plus three cycles (two synchroniser stages and one filter cycle)
// - Timeout programmable per detector, 0 to 100us
// - Filter is last stage after comparator
// - Aux input always taken from comparator, never aux_logic_in
// - Aux analog detector has single lowest range
// - Warning detector shares its rail's range
// - Warnings readable and ORed to sequencer
// - Thirteen ADC channels, any subset selectable
// - Round robin cycles selected channels continuously
// - Averaging takes sixteen conversions per channel
// - Cycle end stores results and compares limits
// - One limit per channel, max or min
// - Limit warnings readable and ORed to sequencer
// - Start by host write or sequencer command
// - Conversion time per channel, temperature longest
// - Results unsigned twelve-bit, full scale at reference
// - Digital aux level or edge detection
// - Edge mode emits pulse of programmable width
// - Digital aux uses same glitch filter
// - Digital aux outputs feed sequencer conditions
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module sicond_core
   import sicond_pkg::*;
(
   input  wire logic                             clk_sys_in,
   input  wire logic                             rst_in,
   input  wire logic [sicond_pkg::N_SFD-1:0]     cmp_fault_in,
   input  wire logic [sicond_pkg::N_AUX-1:0]     aux_logic_in,
   input  wire logic [sicond_pkg::N_AUX-1:0]     aux_warn_cmp_in,
   input  wire logic                             seq_rr_start_in,
   input  wire logic                             adc_ready_in,
   input  wire logic [sicond_pkg::ADC_W-1:0]     adc_code_in,
   input  wire logic [sicond_pkg::ADDR_W-1:0]    addr_in,
   input  wire logic [31:0]                      wdata_in,
   input  wire logic                             wr_in,
   input  wire logic                             rd_in,
   output logic [31:0]                           rdata_out,
   output logic [sicond_pkg::N_SFD-1:0]          fault_out,
   output logic [sicond_pkg::N_AUX-1:0]          aux_cond_out,
   output logic [sicond_pkg::N_AUX-1:0]          aux_analog_out,
   output logic                                  warning_out,
   output logic [3:0]                            adc_ch_out,
   output logic                                  adc_start_out,
   output logic                                  rr_busy_out
);
   import sicond_pkg::*;

   typedef logic [TMR_W-1:0] sic_tmr_t;
   typedef struct packed {
      logic [N_SFD-1:0]              s1;
      logic [N_SFD-1:0]              s2;
      logic [N_AUX-1:0]              w1;
      logic [N_AUX-1:0]              w2;
      logic [N_SFD-1:0][TMR_W-1:0]   fcnt;
      logic [N_SFD-1:0]              filt;
      logic [N_SFD-1:0][TMR_W-1:0]   ftim;
      logic [N_AUX-1:0][TMR_W-1:0]   pw;
      logic [N_AUX-1:0][TMR_W-1:0]   pcnt;
      logic [N_AUX-1:0]              pulse;
      logic [N_AUX-1:0]              aux_dig;
      logic [N_AUX-1:0]              aux_edge;
      logic [N_ADC-1:0]              chsel;
      logic [N_ADC-1:0]              limdir;
      logic [N_ADC-1:0][ADC_W-1:0]   lim;
      logic [N_ADC-1:0][ADC_W-1:0]   res;
      logic [N_ADC-1:0][ACC_W-1:0]   acc;
      logic [N_ADC-1:0]              adc_warn;
      logic                          run;
      logic                          avg;
      sic_rr_t                       rr;
      logic [3:0]                    ch;
      logic [AVG_SH-1:0]             nconv;
      logic                          start;
      logic [31:0]                   rdata;
   } sic_state_t;

   sic_state_t st_reg;
   sic_state_t st_next;
   logic [N_AUX-1:0] wsync;
   logic [N_AUX-1:0] aux_out;
   logic [N_AUX-1:0] sec_warn;

   ////////////////////////////////////////////////////////////////////////
   // Combinational next state

   // Next selected channel above cur, 4'hf when none is left
   function automatic logic [3:0] next_ch(input logic [N_ADC-1:0] sel,
                                           input logic [3:0] cur);
      logic [3:0] r;
      logic       hit;
      r = cur;
      hit = 1'b0;
      for (int i = N_ADC - 1; i >= 0; i--) begin
         if (sel[i] && (i > int'(cur))) begin
            r = 4'(i);
            hit = 1'b1;
         end
      end
      if (!hit) begin
         r = 4'hf;
      end
      return r;
   endfunction

   // Lowest selected channel, 4'hf when nothing is selected
   function automatic logic [3:0] first_ch(input logic [N_ADC-1:0] sel);
      logic [3:0] r;
      r = 4'hf;
      for (int i = N_ADC - 1; i >= 0; i--) begin
         if (sel[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [3:0] nx;
      logic [7:0] idx;
      logic       go;
      logic [N_SFD-1:0] raw;
      nx = 4'h0;
      idx = 8'h00;
      go = 1'b0;
      raw = '0;
      st_next = st_reg;
      st_next.start = 1'b0;
      // Two-stage synchronisers for the asynchronous comparator lines
      st_next.s1 = cmp_fault_in;
      st_next.s2 = st_reg.s1;
      st_next.w1 = aux_warn_cmp_in;
      st_next.w2 = st_reg.w1;
      // Aux uses its comparator line in both modes; aux_logic_in is not used
      raw = st_reg.s2;
      for (int i = 0; i < N_AUX; i++) begin
         if (st_reg.aux_dig[i]) begin
            raw[N_DED+i] = st_reg.s2[N_DED+i];
         end
      end

      // Glitch filter: output follows input only after a stable timeout
      // Any return to the old level restarts the count, so short pulses die
      for (int i = 0; i < N_SFD; i++) begin
         if (raw[i] == st_reg.filt[i]) begin
            st_next.fcnt[i] = '0;
         end else if (st_reg.fcnt[i] >= st_reg.ftim[i]) begin
            st_next.filt[i] = raw[i];
            st_next.fcnt[i] = '0;
         end else begin
            st_next.fcnt[i] = st_reg.fcnt[i] + 1'b1;
         end
      end

      // Edge mode pulse generators
      for (int i = 0; i < N_AUX; i++) begin
         if (st_next.filt[N_DED+i] != st_reg.filt[N_DED+i]) begin
            st_next.pulse[i] = (st_reg.pw[i] != '0);
            st_next.pcnt[i] = '0;
         end else if (st_reg.pulse[i]) begin
            if (st_reg.pcnt[i] + 1'b1 >= st_reg.pw[i]) begin
               st_next.pulse[i] = 1'b0;
            end
            st_next.pcnt[i] = st_reg.pcnt[i] + 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////
      // Register writes
      if (wr_in) begin
         idx = addr_in;
         unique case (1'b1)
            (addr_in == A_CTRL): begin
               st_next.run = wdata_in[CTRL_RUN];
               st_next.avg = wdata_in[CTRL_AVG];
               st_next.start = wdata_in[CTRL_RUN];
            end
            (addr_in == A_AUXMODE): begin
               st_next.aux_dig = wdata_in[N_AUX-1:0];
               st_next.aux_edge =
                  wdata_in[AUX_EDGE_LSB+N_AUX-1:AUX_EDGE_LSB];
            end
            (addr_in == A_CHSEL): begin
               st_next.chsel = wdata_in[N_ADC-1:0];
            end
            (addr_in == A_LIMDIR): begin
               st_next.limdir = wdata_in[N_ADC-1:0];
            end
            // Low TMR_W bits above the maximum clamp to it; higher bits are dropped, so larger values wrap
            (addr_in >= A_FILT0 && addr_in < A_FILT0 + 8'(4*N_SFD)): begin
               st_next.ftim[(idx - A_FILT0) >> 2] =
                  (wdata_in[TMR_W-1:0] > sic_tmr_t'(FILT_MAX_CYC)) ?
                  sic_tmr_t'(FILT_MAX_CYC) : wdata_in[TMR_W-1:0];
            end
            (addr_in >= A_PW0 && addr_in < A_PW0 + 8'(4*N_AUX)): begin
               st_next.pw[(idx - A_PW0) >> 2] =
                  (wdata_in[TMR_W-1:0] > sic_tmr_t'(FILT_MAX_CYC)) ?
                  sic_tmr_t'(FILT_MAX_CYC) : wdata_in[TMR_W-1:0];
            end
            (addr_in >= A_LIM0 && addr_in < A_LIM0 + 8'(4*N_ADC)): begin
               st_next.lim[(idx - A_LIM0) >> 2] = wdata_in[ADC_W-1:0];
            end
            default: ;
         endcase
      end
      if (seq_rr_start_in) begin
         st_next.run = 1'b1;
         st_next.start = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // Round-robin scheduler
      // A one-shot start runs one cycle even when run is already cleared
      go = st_reg.start || st_reg.run;
      unique case (st_reg.rr)
         SIC_IDLE: begin
            nx = first_ch(st_reg.chsel);
            if (go && nx != 4'hf) begin
               st_next.ch = nx;
               st_next.nconv = '0;
               st_next.acc = '0;
               st_next.rr = SIC_CONV;
            end
         end
         SIC_CONV: begin
            // Conversion time is set by the converter's ready pulse
            if (adc_ready_in) begin
               st_next.acc[st_reg.ch] = st_reg.acc[st_reg.ch] +
                  ACC_W'(adc_code_in);
               st_next.nconv = st_reg.nconv + 1'b1;
               if (!st_reg.avg || st_reg.nconv == 4'(AVG_CNT-1)) begin
                  nx = next_ch(st_reg.chsel, st_reg.ch);
                  st_next.nconv = '0;
                  if (nx == 4'hf) begin
                     st_next.rr = SIC_DONE;
                  end else begin
                     st_next.ch = nx;
                  end
               end
            end
         end
         SIC_DONE: begin
            // Averaged sum keeps its top twelve bits as the result
            for (int i = 0; i < N_ADC; i++) begin
               if (st_reg.chsel[i]) begin
                  st_next.res[i] = st_reg.avg ?
                     st_reg.acc[i][ACC_W-1:AVG_SH] :
                     st_reg.acc[i][ADC_W-1:0];
                  st_next.adc_warn[i] = st_reg.limdir[i] ?
                     (st_next.res[i] < st_reg.lim[i]) :
                     (st_next.res[i] > st_reg.lim[i]);
               end
            end
            st_next.rr = SIC_IDLE;
         end
         default: st_next.rr = SIC_IDLE;
      endcase

      ////////////////////////////////////////////////////////////////////
      // Read data, one cycle later; unmapped addresses read as zero
      st_next.rdata = 32'h0;
      if (rd_in) begin
         idx = addr_in;
         unique case (1'b1)
            (addr_in == A_CTRL): begin
               st_next.rdata = {30'h0, st_reg.avg, st_reg.run};
            end
            (addr_in == A_AUXMODE): begin
               st_next.rdata = {19'h0, st_reg.aux_edge, 3'h0,
                                st_reg.aux_dig};
            end
            (addr_in == A_CHSEL): begin
               st_next.rdata = {19'h0, st_reg.chsel};
            end
            (addr_in == A_LIMDIR): begin
               st_next.rdata = {19'h0, st_reg.limdir};
            end
            (addr_in == A_STATUS): begin
               st_next.rdata = {11'h0, aux_out, st_reg.filt,
                                5'h0, (st_reg.rr != SIC_IDLE)};
            end
            (addr_in == A_WARN): begin
               st_next.rdata = {14'h0, sec_warn, st_reg.adc_warn};
            end
            (addr_in >= A_FILT0 && addr_in < A_FILT0 + 8'(4*N_SFD)): begin
               st_next.rdata = {19'h0, st_reg.ftim[(idx - A_FILT0) >> 2]};
            end
            (addr_in >= A_PW0 && addr_in < A_PW0 + 8'(4*N_AUX)): begin
               st_next.rdata = {19'h0, st_reg.pw[(idx - A_PW0) >> 2]};
            end
            (addr_in >= A_LIM0 && addr_in < A_LIM0 + 8'(4*N_ADC)): begin
               st_next.rdata = {20'h0, st_reg.lim[(idx - A_LIM0) >> 2]};
            end
            (addr_in >= A_RES0 && addr_in < A_RES0 + 8'(4*N_ADC)): begin
               st_next.rdata = {20'h0, st_reg.res[(idx - A_RES0) >> 2]};
            end
            default: st_next.rdata = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   // Reset leaves every channel selected so a bare start converts all
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         st_reg <= '0;
         st_reg.rr <= SIC_IDLE;
         st_reg.chsel <= CHSEL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Only the second synchroniser stage feeds the warning logic
   assign wsync = st_reg.w2;
   genvar g;
   generate
      for (g = 0; g < N_AUX; g++) begin : g_aux
         // Level follows filtered input, edge gives timed pulse
         assign aux_out[g] = st_reg.aux_edge[g] ? st_reg.pulse[g] :
                             st_reg.filt[N_DED+g];
         // Secondary detector only live in digital mode, same range
         assign sec_warn[g] = st_reg.aux_dig[g] & wsync[g];
         assign aux_cond_out[g] = st_reg.aux_dig[g] & aux_out[g];
         assign aux_analog_out[g] = ~st_reg.aux_dig[g];
      end
   endgenerate
   assign fault_out = st_reg.filt;
   assign warning_out = (|sec_warn) | (|st_reg.adc_warn);
   assign adc_ch_out = st_reg.ch;
   assign adc_start_out = (st_reg.rr == SIC_CONV);
   assign rr_busy_out = (st_reg.rr != SIC_IDLE);
   assign rdata_out = st_reg.rdata;
endmodule

// >>> test/sicond_sva.sv
// Port-level assertions for the supply input conditioning block
`timescale 1ns/1ps
module sicond_sva
   import sicond_pkg::*;
(
   input wire logic                          clk_sys_in,
   input wire logic                          rst_in,
   input wire logic [sicond_pkg::ADDR_W-1:0] addr_in,
   input wire logic [31:0]                   wdata_in,
   input wire logic                          wr_in,
   input wire logic                          rd_in,
   input wire logic                          seq_rr_start_in,
   input wire logic                          adc_ready_in,
   input wire logic [31:0]                   rdata_out,
   input wire logic [sicond_pkg::N_AUX-1:0]  aux_analog_out,
   input wire logic [3:0]                    adc_ch_out,
   input wire logic                          adc_start_out,
   input wire logic                          rr_busy_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////
   sequence s_wr_lim;
      wr_in && addr_in == A_LIM0;
   endsequence
   sequence s_rd_lim;
      rd_in && addr_in == A_LIM0;
   endsequence
   AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside a read");
   AST_RD_UNMAPPED: assert property (rd_in && addr_in inside
      {8'h18, 8'h1c, 8'hfc} |=> rdata_out == 32'h0)
      else $error("unmapped read not zero");
   AST_LIM_RDBK: assert property (s_wr_lim ##2 s_rd_lim |=>
      rdata_out == {20'h0, $past(wdata_in[11:0], 3)})
      else $error("limit read back wrong");
   AST_AUX_MODE: assert property (wr_in && addr_in == A_AUXMODE |=>
      aux_analog_out == ~$past(wdata_in[4:0]))
      else $error("aux mode not applied");
   AST_CH_RANGE: assert property (adc_start_out |-> adc_ch_out < 4'd13)
      else $error("channel out of range");
   AST_START_BUSY: assert property (adc_start_out |-> rr_busy_out)
      else $error("converting while idle");
   AST_CONV_HOLD: assert property (adc_start_out && !adc_ready_in |=>
      adc_start_out && $stable(adc_ch_out))
      else $error("conversion left before ready");
   AST_SEQ_START: assert property (seq_rr_start_in && !rr_busy_out
      |-> ##[1:3] rr_busy_out)
      else $error("sequencer start ignored");
endmodule
bind sicond_core sicond_sva sva_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .seq_rr_start_in(seq_rr_start_in), .adc_ready_in(adc_ready_in),
   .rdata_out(rdata_out), .aux_analog_out(aux_analog_out),
   .adc_ch_out(adc_ch_out), .adc_start_out(adc_start_out),
   .rr_busy_out(rr_busy_out));

// >>> test/sicond_adc_model.sv
// Conversion engine model answering the round robin scheduler
`timescale 1ns/1ps
module sicond_adc_model
   import sicond_pkg::*;
(
   input  wire logic                         clk_sys_in,
   input  wire logic                         rst_in,
   input  wire logic                         start_in,
   input  wire logic [3:0]                   ch_in,
   input  wire logic [sicond_pkg::ADC_W-1:0] code_base_in,
   input  wire logic                         slow_in,
   output logic                              ready_out = 1'b0,
   output logic [sicond_pkg::ADC_W-1:0]      code_out = 12'h5a5
);
   int cnt = 0;
   // Code line toggles whenever no result is offered
   always @(posedge clk_sys_in) begin
      if (rst_in || !start_in || ready_out) begin
         cnt <= 0;
         ready_out <= 1'b0;
         code_out <= ~code_out;
      end else if (cnt >= (ch_in >= 4'(FIRST_TEMP_CH) ? 12 : 3)
                   + (slow_in ? 20 : 0)) begin
         ready_out <= 1'b1;
         code_out <= code_base_in ^ {8'h00, ch_in};
      end else begin
         cnt <= cnt + 1;
         code_out <= ~code_out;
      end
   end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the supply input conditioning block
`timescale 1ns/1ps
module testbench;
   import sicond_pkg::*;
   logic        clk_sys_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
   logic        seq_rr_start_in = 1'b0, slow = 1'b0, rd_q = 1'b0;
   logic [9:0]  cmp_fault_in = '0, fault_out;
   logic [4:0]  aux_warn_cmp_in = '0, aux_cond_out, aux_analog_out;
   logic [7:0]  addr_in = '0;
   logic [31:0] wdata_in = '0, rdata_out, exp_q[$];
   logic [11:0] adc_code_in, code_base = '0;
   logic [3:0]  adc_ch_out, chs[$];
   logic        adc_ready_in, warning_out, adc_start_out, rr_busy_out;
   int          n_errors = 0, n_checks = 0, seed = 32'he6a1, cnt, lat, hi;
   wire [14:0]  ov = {aux_cond_out, fault_out};
   always #10 clk_sys_in = ~clk_sys_in;
   sicond_core dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .cmp_fault_in(cmp_fault_in), .aux_logic_in(5'h00),
      .aux_warn_cmp_in(aux_warn_cmp_in), .seq_rr_start_in(seq_rr_start_in),
      .adc_ready_in(adc_ready_in), .adc_code_in(adc_code_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .fault_out(fault_out),
      .aux_cond_out(aux_cond_out), .aux_analog_out(aux_analog_out),
      .warning_out(warning_out), .adc_ch_out(adc_ch_out),
      .adc_start_out(adc_start_out), .rr_busy_out(rr_busy_out));
   sicond_adc_model adc_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .start_in(adc_start_out), .ch_in(adc_ch_out), .code_base_in(code_base),
      .slow_in(slow), .ready_out(adc_ready_in), .code_out(adc_code_in));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   always @(posedge clk_sys_in) begin
      rd_q <= rd_in;
      if (rd_q) begin
         chk("rdata", exp_q.pop_front(), rdata_out);
      end
   end
   task automatic wr(logic [7:0] a, logic [31:0] d);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      exp_q.push_back(e);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   // Raise one comparator line, watch one output for high cycles
   task automatic pulse(int b, int len, int win, int o);
      lat = -1;
      hi = 0;
      cmp_fault_in[b] <= 1'b1;
      for (int k = 1; k <= win; k++) begin
         @(posedge clk_sys_in);
         if (k == len) begin
            cmp_fault_in[b] <= 1'b0;
         end
         if (ov[o] === 1'b1) begin
            hi++;
            if (lat < 0) begin
               lat = k;
            end
         end
      end
   endtask
   task automatic count_rr();
      cnt = 0;
      chs.delete();
      for (int k = 0; k < 5000 && rr_busy_out !== 1'b0; k++) begin
         @(posedge clk_sys_in);
         if (adc_ready_in === 1'b1) begin
            cnt++;
            chs.push_back(adc_ch_out);
         end
      end
      if (rr_busy_out !== 1'b0) begin
         n_errors++;
         $display("BAD rr_busy expected 0 seen %b", rr_busy_out);
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      chk("aux_rst", 32'h1f, aux_analog_out);
      rd(A_CHSEL, 32'h1fff);
      wr(8'h18, 32'hffff);
      rd(8'h18, 32'h0);
      wr(A_FILT0, 32'hffff);
      rd(A_FILT0, 32'd5000);
      wr(A_FILT0, 32'd10);
      wr(A_FILT0 + 8'h04, 32'd40);
      pulse(0, 8, 40, 0);
      chk("short", 0, hi);
      pulse(0, 30, 60, 0);
      chk("long", 30, hi);
      chk("delay", 14, lat);
      pulse(1, 30, 60, 1);
      chk("per_det", 0, hi);
      wr(A_FILT0 + 8'h14, 32'd4);
      wr(A_AUXMODE, 32'h0203);
      wr(A_PW0 + 8'h04, 32'd6);
      chk("aux_mode", 32'h1c, aux_analog_out);
      pulse(5, 3, 20, 10);
      chk("aux_glitch", 0, hi);
      pulse(5, 12, 40, 10);
      chk("aux_level", 12, hi);
      pulse(6, 40, 25, 11);
      chk("aux_edge", 6, hi);
      cmp_fault_in[6] <= 1'b0;
      @(posedge clk_sys_in);
      pulse(7, 10, 20, 12);
      chk("aux_analog", 0, hi);
      aux_warn_cmp_in <= 5'h01;
      repeat (8) @(posedge clk_sys_in);
      chk("sec_warn", 1, warning_out);
      rd(A_WARN, 32'h2000);
      aux_warn_cmp_in <= 5'h04;
      repeat (8) @(posedge clk_sys_in);
      chk("sec_mask", 0, warning_out);
      aux_warn_cmp_in <= 5'h00;
      code_base <= 12'($random(seed)) & 12'h7ff | 12'h400;
      slow <= 1'b1;
      wr(A_CHSEL, 32'h1001);
      wr(A_LIM0, 32'h0);
      rd(A_LIM0, 32'h0);
      wr(A_LIM0 + 8'h30, 32'hfff);
      wr(A_CTRL, 32'h1);
      wr(A_CTRL, 32'h0);
      count_rr();
      chk("conv_n", 2, cnt);
      chk("order", 32'h0c, {chs[0], chs[1]});
      rd(A_RES0, {20'h0, code_base});
      rd(A_RES0 + 8'h30, {20'h0, code_base ^ 12'h00c});
      chk("adc_warn", 1, warning_out);
      rd(A_WARN, 32'h1);
      wr(A_CTRL, 32'h2);
      seq_rr_start_in <= 1'b1;
      @(posedge clk_sys_in);
      seq_rr_start_in <= 1'b0;
      @(posedge clk_sys_in);
      wr(A_CTRL, 32'h2);
      count_rr();
      chk("avg_n", 32, cnt);
      rd(A_RES0, {20'h0, code_base});
      repeat (3) @(posedge clk_sys_in);
      end_sim();
   end
endmodule
